// ---- core/mmd_pkg.sv ----
// package: address map, flash geometry, timing and target codes
package mmd_pkg;

   localparam int          ADDR_W          = 24;
   localparam int          SEG_W           = 8;
   localparam int          PAGE_W          = 2;
   localparam int          OFS_W           = 16;
   localparam logic [7:0]  SYS_SEG         = 8'h00;
   localparam int          NUM_SEGS        = 256;
   localparam int          SEG_BYTES       = 65536;
   localparam int          PAGE_BYTES      = 16384;

   localparam logic [23:0] FLASH_LO        = 24'hc00000;
   localparam logic [23:0] FLASH_HI_BIG    = 24'hc0ffff;
   localparam logic [23:0] FLASH_HI_SMALL  = 24'hc07fff;
   localparam logic [23:0] PROG_SRAM_LO    = 24'he00000;
   localparam logic [23:0] PROG_SRAM_HI    = 24'he007ff;
   localparam logic [23:0] DATA_SRAM_LO    = 24'h00c000;
   localparam logic [23:0] DATA_SRAM_HI    = 24'h00c7ff;
   localparam logic [23:0] DUAL_RAM_LO     = 24'h00f600;
   localparam logic [23:0] DUAL_RAM_HI     = 24'h00fdff;
   localparam logic [23:0] DUAL_RAM_BIT_LO = 24'h00fd00;
   localparam logic [23:0] SPEC_REGS_LO    = 24'h00fe00;
   localparam logic [23:0] SPEC_REGS_HI    = 24'h00ffff;
   localparam logic [23:0] EXT_REGS_LO     = 24'h00f000;
   localparam logic [23:0] EXT_REGS_HI     = 24'h00f1ff;
   localparam logic [23:0] FREG_LO         = 24'hfff000;
   localparam logic [23:0] FREG_HI         = 24'hffffff;
   localparam logic [15:0] TRAP_CODE       = 16'h1e9b;

   localparam int          SMALL_SECT_B    = 8192;
   localparam int          BIG_SECT_B      = 32768;
   localparam int          NUM_SMALL_SECT  = 4;
   localparam int          PROG_BLOCK_B    = 128;
   localparam int          FLASH_RD_W      = 64;
   localparam int          ECC_W           = 8;

   localparam int          CLK_MHZ         = 100;
   localparam int          PROG_MAX_US     = 5000;
   localparam int          PROG_TYP_US     = 2000;
   localparam int          ERASE_MAX_US    = 500000;
   localparam int          ERASE_TYP_US    = 200000;
   localparam int          PROG_TYP_CYC    = PROG_TYP_US * CLK_MHZ;
   localparam int          ERASE_TYP_CYC   = ERASE_TYP_US * CLK_MHZ;
   localparam int          PROG_MAX_CYC    = PROG_MAX_US * CLK_MHZ;
   localparam int          ERASE_MAX_CYC   = ERASE_MAX_US * CLK_MHZ;

   localparam logic [15:0] PWD_FIRST       = 16'ha5a5;
   localparam logic [15:0] PWD_SECOND      = 16'h5a5a;
   localparam int          UNLOCK_CYC      = 1024;

   typedef enum logic [6:0] {
      MMD_TGT_NONE      = 7'h00,
      MMD_TGT_FLASH     = 7'h01,
      MMD_TGT_PROG_SRAM = 7'h02,
      MMD_TGT_DATA_SRAM = 7'h04,
      MMD_TGT_DUAL_RAM  = 7'h08,
      MMD_TGT_SPEC_REGS = 7'h10,
      MMD_TGT_EXT_REGS  = 7'h20,
      MMD_TGT_FREG      = 7'h40
   } mmd_tgt_e;

   typedef enum logic [2:0] {
      MMD_FL_IDLE  = 3'b001,
      MMD_FL_PROG  = 3'b010,
      MMD_FL_ERASE = 3'b100
   } mmd_fl_e;

endpackage : mmd_pkg

// ---- core/mmd_region_dec.sv ----
// region decoder: one-hot target from a 24-bit address
`timescale 1ns/1ps
module mmd_region_dec
   import mmd_pkg::*;
#(
   parameter bit BIG_FLASH = 1'b1
)(
   // address in
   input  wire logic [23:0] addr,
   // decode out
   output mmd_tgt_e         tgt,
   output logic             bit_addr,
   output logic             err
);

   function automatic logic in_rng(input logic [23:0] a,
                                   input logic [23:0] lo,
                                   input logic [23:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction : in_rng

   logic sys_seg;
   logic [23:0] fl_hi;

   assign sys_seg = (addr[23:16] == SYS_SEG);
   assign fl_hi   = BIG_FLASH ? FLASH_HI_BIG : FLASH_HI_SMALL;

   // pure combinational, priority chain gives at most one target, none when no range matches
   always_comb begin
      tgt = MMD_TGT_NONE;
      if (in_rng(addr, FREG_LO, FREG_HI)) begin
         tgt = MMD_TGT_FREG;
      end else if (in_rng(addr, FLASH_LO, fl_hi)) begin
         tgt = MMD_TGT_FLASH;
      end else if (in_rng(addr, PROG_SRAM_LO, PROG_SRAM_HI)) begin
         tgt = MMD_TGT_PROG_SRAM;
      end else if (sys_seg && BIG_FLASH &&
                   in_rng(addr, DATA_SRAM_LO, DATA_SRAM_HI)) begin
         tgt = MMD_TGT_DATA_SRAM;
      end else if (sys_seg && in_rng(addr, DUAL_RAM_LO, DUAL_RAM_HI)) begin
         tgt = MMD_TGT_DUAL_RAM;
      end else if (sys_seg && in_rng(addr, SPEC_REGS_LO, SPEC_REGS_HI)) begin
         tgt = MMD_TGT_SPEC_REGS;
      end else if (sys_seg && in_rng(addr, EXT_REGS_LO, EXT_REGS_HI)) begin
         tgt = MMD_TGT_EXT_REGS;
      end
   end

   // top 256 bytes of dual-port ram plus both register areas
   assign bit_addr = (tgt == MMD_TGT_DUAL_RAM && addr >= DUAL_RAM_BIT_LO) ||
                     tgt == MMD_TGT_SPEC_REGS ||
                     tgt == MMD_TGT_EXT_REGS;
   assign err      = (tgt == MMD_TGT_NONE);

endmodule : mmd_region_dec

// ---- core/mmd_ecc.sv ----
// single-error correcting check over a 64-bit flash word
`timescale 1ns/1ps
module mmd_ecc
   import mmd_pkg::*;
(
   // raw word
   input  wire logic [63:0] data_in,
   input  wire logic [7:0]  chk_in,
   // corrected word
   output logic [63:0]      data_out,
   output logic             corrected
);

   function automatic logic [7:0] syn_of(input logic [63:0] d);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (d[i]) begin
            s = s ^ 8'(i + 1);
         end
      end
      syn_of = s;
   endfunction : syn_of

   logic [7:0] syn;

   assign syn = syn_of(data_in) ^ chk_in;

   always_comb begin
      data_out = data_in;
      for (int i = 0; i < 64; i++) begin
         if (syn == 8'(i + 1)) begin
            data_out[i] = ~data_in[i];
         end
      end
   end

   assign corrected = (syn != 8'h00);

endmodule : mmd_ecc

// ---- core/mmd_memory_map_address_decoder.sv ----
// memory map decoder: fetch and data routing, flash control
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - linear 16 MB, 256 segments, 16K pages
// - byte and word access everywhere
// - data memories and registers only in segment 0
// - fetches go via program-side manager only
// - data goes via data-side manager
// - system bus links data side to program memories, one way
// - flash C0'0000 to C0'FFFF or C0'7FFF
// - four 8K sectors, 32K sector, 128B blocks
// - write protect per pair of small sectors
// - read protect, password unlocks temporarily
// - flash reads 64 bits in one cycle
// - flash reads pass error correction
// - program 2-5 ms, erase 200-500 ms
// - program sram E0'0000 to E0'07FF
// - data sram 00'C000 to 00'C7FF, big only
// - dual-port ram 00'F600 to 00'FDFF
// - top 256 dual-port bytes bit addressable
// - register areas FE00-FFFF and F000-F1FF
// - flash register space returns trap code
//////////////////////////////////////////////////////////////////////////////
module mmd_memory_map_address_decoder
   import mmd_pkg::*;
#(
   parameter bit BIG_FLASH    = 1'b1,
   parameter int PROG_CYCLES  = PROG_TYP_CYC,
   parameter int ERASE_CYCLES = ERASE_TYP_CYC
)(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // instruction fetch port
   input  wire logic        FETCH_REQ,
   input  wire logic [23:0] FETCH_ADDR,
   output logic             FETCH_VALID,
   output logic [63:0]      FETCH_DATA,
   output logic             FETCH_ERR,
   // data access port
   input  wire logic        DATA_REQ,
   input  wire logic [23:0] DATA_ADDR,
   input  wire logic        DATA_WE,
   input  wire logic        DATA_BYTE,
   input  wire logic [15:0] DATA_WDATA,
   output logic             DATA_VALID,
   output logic [15:0]      DATA_RDATA,
   output logic             DATA_ERR,
   output logic             DATA_BIT_OK,
   // flash array
   output logic [23:0]      FL_ADDR,
   input  wire logic [63:0] FL_RDATA,
   input  wire logic [7:0]  FL_RCHK,
   // program sram
   output logic             PS_SEL,
   output logic [23:0]      PS_ADDR,
   output logic             PS_WE,
   output logic [1:0]       PS_BE,
   output logic [15:0]      PS_WDATA,
   input  wire logic [63:0] PS_RDATA,
   // data-side targets
   output logic [6:0]       DS_SEL,
   output logic [23:0]      DS_ADDR,
   output logic             DS_WE,
   output logic [1:0]       DS_BE,
   output logic [15:0]      DS_WDATA,
   input  wire logic [15:0] DS_RDATA,
   // flash control
   input  wire logic        FC_PROG,
   input  wire logic        FC_ERASE,
   input  wire logic [2:0]  FC_SECTOR,
   input  wire logic [1:0]  FC_WP_PAIR,
   input  wire logic        FC_RP_EN,
   input  wire logic        FC_PWD_VALID,
   input  wire logic [15:0] FC_PWD,
   output logic             FC_BUSY,
   output logic             FC_DONE,
   output logic             FC_REFUSED,
   output logic             FC_UNLOCKED,
   output logic [15:0]      FC_SECT_ERASED
);

   mmd_tgt_e    f_tgt, d_tgt;
   logic        f_err, d_err, d_bit;
   logic [63:0] ecc_data;
   logic        ecc_fix;
   logic        rd_blocked;
   logic        d_to_prog;
   logic [1:0]  be;

   ////////////////////////////////////////////////////////////////////////////
   // decode both ports
   mmd_region_dec #(.BIG_FLASH(BIG_FLASH)) u_fdec (
      .addr     (FETCH_ADDR),
      .tgt      (f_tgt),
      .bit_addr (),
      .err      (f_err)
   );

   mmd_region_dec #(.BIG_FLASH(BIG_FLASH)) u_ddec (
      .addr     (DATA_ADDR),
      .tgt      (d_tgt),
      .bit_addr (d_bit),
      .err      (d_err)
   );

   mmd_ecc u_ecc (
      .data_in   (FL_RDATA),
      .chk_in    (FL_RCHK),
      .data_out  (ecc_data),
      .corrected (ecc_fix)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read protection and password unlock
   logic        pwd_step_r;
   logic [10:0] unlock_cnt_r;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pwd_step_r   <= 1'b0;
         unlock_cnt_r <= 11'h000;
      end else begin
         if (unlock_cnt_r != 11'h000) begin
            unlock_cnt_r <= unlock_cnt_r - 11'h001;
         end
         if (FC_PWD_VALID) begin
            if (!pwd_step_r && FC_PWD == PWD_FIRST) begin
               pwd_step_r <= 1'b1;
            end else if (pwd_step_r && FC_PWD == PWD_SECOND) begin
               pwd_step_r   <= 1'b0;
               unlock_cnt_r <= 11'(UNLOCK_CYC);
            end else begin
               pwd_step_r <= 1'b0;
            end
         end
      end
   end

   assign FC_UNLOCKED = (unlock_cnt_r != 11'h000);
   assign rd_blocked  = FC_RP_EN && !FC_UNLOCKED;

   ////////////////////////////////////////////////////////////////////////////
   // byte enables from width and address bit 0
   assign be = DATA_BYTE ? (DATA_ADDR[0] ? 2'b10 : 2'b01) : 2'b11;

   // data requests to flash or program sram cross the system bus
   assign d_to_prog = DATA_REQ &&
      (d_tgt == MMD_TGT_FLASH || d_tgt == MMD_TGT_PROG_SRAM);

   // flash address: fetch wins, data operand reads otherwise
   assign FL_ADDR = (FETCH_REQ && f_tgt == MMD_TGT_FLASH) ?
                    FETCH_ADDR : DATA_ADDR;

   // program sram: written by data side over the system bus
   assign PS_SEL   = (FETCH_REQ && f_tgt == MMD_TGT_PROG_SRAM) ||
                     (d_to_prog && d_tgt == MMD_TGT_PROG_SRAM);
   assign PS_ADDR  = (FETCH_REQ && f_tgt == MMD_TGT_PROG_SRAM) ?
                     FETCH_ADDR : DATA_ADDR;
   assign PS_WE    = d_to_prog && d_tgt == MMD_TGT_PROG_SRAM &&
                     DATA_WE && !(FETCH_REQ && f_tgt == MMD_TGT_PROG_SRAM);
   assign PS_BE    = be;
   assign PS_WDATA = DATA_WDATA;

   // data-side manager drives system-segment targets and flash register space
   assign DS_SEL   = DATA_REQ && !d_to_prog ? 7'(d_tgt) : 7'h00;
   assign DS_ADDR  = DATA_ADDR;
   assign DS_WE    = DATA_WE && DATA_REQ && !d_to_prog &&
                     d_tgt != MMD_TGT_FREG;
   assign DS_BE    = be;
   assign DS_WDATA = DATA_WDATA;

   ////////////////////////////////////////////////////////////////////////////
   // fetch answer, one cycle after request
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         FETCH_VALID <= 1'b0;
         FETCH_DATA  <= 64'h0;
         FETCH_ERR   <= 1'b0;
      end else begin
         FETCH_VALID <= FETCH_REQ;
         FETCH_ERR   <= FETCH_REQ && (f_err ||
            f_tgt == MMD_TGT_DATA_SRAM || f_tgt == MMD_TGT_DUAL_RAM ||
            f_tgt == MMD_TGT_SPEC_REGS || f_tgt == MMD_TGT_EXT_REGS ||
            f_tgt == MMD_TGT_FREG ||
            (f_tgt == MMD_TGT_FLASH && rd_blocked));
         if (FETCH_REQ && f_tgt == MMD_TGT_FLASH && !rd_blocked) begin
            FETCH_DATA <= ecc_data;
         end else if (FETCH_REQ && f_tgt == MMD_TGT_PROG_SRAM) begin
            FETCH_DATA <= PS_RDATA;
         end else begin
            FETCH_DATA <= 64'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data answer, one cycle after request
   logic [15:0] d_rd_nxt;
   logic [63:0] d_word64;

   assign d_word64 = (d_tgt == MMD_TGT_FLASH) ? ecc_data : PS_RDATA;

   always_comb begin
      d_rd_nxt = 16'h0000;
      if (d_tgt == MMD_TGT_FREG) begin
         d_rd_nxt = TRAP_CODE;
      end else if (d_to_prog) begin
         case (DATA_ADDR[2:1])
            2'b00:   d_rd_nxt = d_word64[15:0];
            2'b01:   d_rd_nxt = d_word64[31:16];
            2'b10:   d_rd_nxt = d_word64[47:32];
            default: d_rd_nxt = d_word64[63:48];
         endcase
         if (d_tgt == MMD_TGT_FLASH && rd_blocked) begin
            d_rd_nxt = 16'h0000;
         end
      end else if (!d_err) begin
         d_rd_nxt = DS_RDATA;
      end
      if (DATA_BYTE) begin
         d_rd_nxt = {8'h00, DATA_ADDR[0] ? d_rd_nxt[15:8]
                                         : d_rd_nxt[7:0]};
      end
   end

   // fetch holds the program memory port: a same-cycle data access to the same memory stalls
   logic d_ps_stall;
   assign d_ps_stall = d_to_prog && FETCH_REQ &&
                       ((d_tgt == MMD_TGT_PROG_SRAM &&
                         f_tgt == MMD_TGT_PROG_SRAM) ||
                        (d_tgt == MMD_TGT_FLASH &&
                         f_tgt == MMD_TGT_FLASH));

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         DATA_VALID  <= 1'b0;
         DATA_RDATA  <= 16'h0000;
         DATA_ERR    <= 1'b0;
         DATA_BIT_OK <= 1'b0;
      end else begin
         DATA_VALID  <= DATA_REQ && !d_ps_stall;
         DATA_ERR    <= DATA_REQ && !d_ps_stall && (d_err ||
            (d_tgt == MMD_TGT_FLASH && (DATA_WE || rd_blocked)));
         DATA_BIT_OK <= DATA_REQ && d_bit;
         DATA_RDATA  <= (DATA_REQ && !DATA_WE) ? d_rd_nxt : 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program / erase sequencer
   mmd_fl_e     fl_st_r;
   logic [31:0] fl_cnt_r;
   logic [2:0]  fl_sect_r;
   logic        sect_ok, sect_wp;

   // sectors 0..3 small, 4 is the large one on the big part only
   assign sect_ok = (FC_SECTOR < 3'(NUM_SMALL_SECT)) ||
                    (BIG_FLASH && FC_SECTOR == 3'(NUM_SMALL_SECT));
   assign sect_wp = (FC_SECTOR < 3'(NUM_SMALL_SECT)) &&
                    FC_WP_PAIR[FC_SECTOR[1]];

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fl_st_r    <= MMD_FL_IDLE;
         fl_cnt_r   <= 32'h0;
         fl_sect_r  <= 3'h0;
         FC_DONE    <= 1'b0;
         FC_REFUSED <= 1'b0;
      end else begin
         FC_DONE    <= 1'b0;
         FC_REFUSED <= 1'b0;
         case (fl_st_r)
            MMD_FL_IDLE: begin
               if (FC_PROG || FC_ERASE) begin
                  if (!sect_ok || sect_wp || rd_blocked) begin
                     FC_REFUSED <= 1'b1;
                  end else begin
                     fl_sect_r <= FC_SECTOR;
                     fl_st_r   <= FC_ERASE ? MMD_FL_ERASE : MMD_FL_PROG;
                     fl_cnt_r  <= FC_ERASE ? 32'(ERASE_CYCLES - 1)
                                           : 32'(PROG_CYCLES - 1);
                  end
               end
            end
            MMD_FL_PROG, MMD_FL_ERASE: begin
               if (fl_cnt_r == 32'h0) begin
                  fl_st_r <= MMD_FL_IDLE;
                  FC_DONE <= 1'b1;
               end else begin
                  fl_cnt_r <= fl_cnt_r - 32'h1;
               end
            end
            default: fl_st_r <= MMD_FL_IDLE;
         endcase
      end
   end

   assign FC_BUSY = (fl_st_r != MMD_FL_IDLE);

   // sector flags, set when a program or an erase completes, one bit per sector
   logic [15:0] erased_r;
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         erased_r <= 16'h0000;
      end else if (FC_DONE) begin
         erased_r[fl_sect_r] <= (fl_st_r == MMD_FL_IDLE);
      end
   end
   assign FC_SECT_ERASED = erased_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   fetch_err_a: assert property (@(posedge CLK) disable iff (RST)
      FETCH_REQ && f_tgt == MMD_TGT_NONE |=> FETCH_ERR && FETCH_DATA == 0)
      else $error("reserved fetch not flagged");
   trap_code_a: assert property (@(posedge CLK) disable iff (RST)
      DATA_REQ && !DATA_WE && !DATA_BYTE && d_tgt == MMD_TGT_FREG
      |=> DATA_RDATA == TRAP_CODE)
      else $error("trap code missing");
   seg_zero_a: assert property (@(posedge CLK) disable iff (RST)
      DATA_ADDR[23:16] != 8'h00 |-> d_tgt inside {MMD_TGT_NONE,
      MMD_TGT_FLASH, MMD_TGT_PROG_SRAM, MMD_TGT_FREG})
      else $error("system target outside segment 0");
   one_hot_a: assert property (@(posedge CLK) disable iff (RST)
      $onehot0(DS_SEL))
      else $error("several targets selected");
   fetch_lat_a: assert property (@(posedge CLK) disable iff (RST)
      FETCH_REQ |=> FETCH_VALID)
      else $error("fetch not one cycle");
   wp_pair_a: assert property (@(posedge CLK) disable iff (RST)
      !FC_BUSY && FC_PROG && FC_SECTOR < 3'h4 && FC_WP_PAIR[FC_SECTOR[1]]
      |=> FC_REFUSED && !FC_BUSY)
      else $error("protected pair not refused");
   rd_prot_a: assert property (@(posedge CLK) disable iff (RST)
      FETCH_REQ && f_tgt == MMD_TGT_FLASH && rd_blocked |=> FETCH_ERR)
      else $error("read protection bypassed");
   ds_route_a: assert property (@(posedge CLK) disable iff (RST)
      DATA_REQ && d_tgt == MMD_TGT_DATA_SRAM |-> DS_SEL == 7'h04 && !PS_WE)
      else $error("data sram not via data side");
   byte_be_a: assert property (@(posedge CLK) disable iff (RST)
      DATA_REQ && DATA_BYTE |-> $onehot(DS_BE))
      else $error("byte access not one lane");
   fetch_flash_c: cover property (@(posedge CLK) disable iff (RST)
      FETCH_REQ && f_tgt == MMD_TGT_FLASH ##1 FETCH_VALID);
   sysbus_c: cover property (@(posedge CLK) disable iff (RST)
      FETCH_REQ && d_to_prog);
   unlock_c: cover property (@(posedge CLK) disable iff (RST)
      $rose(FC_UNLOCKED));
   ecc_fix_c: cover property (@(posedge CLK) disable iff (RST)
      FETCH_REQ && f_tgt == MMD_TGT_FLASH && ecc_fix);

endmodule : mmd_memory_map_address_decoder

// ---- verification/mmd_mem_model.sv ----
// memory model: flash array, program sram and data-side targets
`timescale 1ns/1ps
module mmd_mem_model
   import mmd_pkg::*;
(
   // flash array
   input  wire logic [23:0] fl_addr,
   input  wire logic        corrupt,
   output logic [63:0]      fl_rdata,
   output logic [7:0]       fl_rchk,
   // program sram and data-side targets
   input  wire logic [23:0] ps_addr,
   input  wire logic [23:0] ds_addr,
   output logic [63:0]      ps_rdata,
   output logic [15:0]      ds_rdata
);
   logic [63:0] line;
   // 64-bit line with check byte, same cycle
   always_comb begin
      line = {8'hc3, fl_addr[23:3], 3'b0, 8'h5e, fl_addr[23:3], 3'b0};
      fl_rchk = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (line[i]) begin
            fl_rchk = fl_rchk ^ 8'(i + 1);
         end
      end
      // one bit flipped on command to exercise correction
      fl_rdata = corrupt ? (line ^ 64'h20) : line;
   end
   assign ps_rdata = {2{8'h96, ps_addr}};
   assign ds_rdata = ds_addr[15:0] ^ 16'h0f0f;
endmodule : mmd_mem_model

// ---- verification/tb_memory_map_address_decoder.sv ----
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module tb_memory_map_address_decoder;
   import mmd_pkg::*;
   logic        clk = 0, rst = 1, corrupt = 0;
   logic        freq = 0, dreq = 0, dwe = 0, dbyte = 0;
   logic [23:0] fadr = 0, dadr = 0;
   logic [15:0] dwd = 0, pwd = 0;
   logic        prog = 0, erase = 0, rp = 0, pv = 0;
   logic [2:0]  sect = 0;
   logic [1:0]  wp = 0;
   logic        fv, fe, dv, de, dbit, pss, pswe, dswe, busy, done, refd, unl;
   logic [63:0] fd, flr, psr;
   logic [23:0] fla, psa, dsa;
   logic [15:0] dr, pswd, dswd, dsr, serased;
   logic [7:0]  flc;
   logic [6:0]  dss;
   logic [1:0]  psbe, dsbe;
   int          n_fail = 0, tests_run = 0;

   initial forever #5 clk = ~clk;

   mmd_memory_map_address_decoder #(.PROG_CYCLES(8), .ERASE_CYCLES(16)) DUT (
      .CLK(clk), .RST(rst), .FETCH_REQ(freq), .FETCH_ADDR(fadr),
      .FETCH_VALID(fv), .FETCH_DATA(fd), .FETCH_ERR(fe),
      .DATA_REQ(dreq), .DATA_ADDR(dadr), .DATA_WE(dwe), .DATA_BYTE(dbyte),
      .DATA_WDATA(dwd), .DATA_VALID(dv), .DATA_RDATA(dr), .DATA_ERR(de),
      .DATA_BIT_OK(dbit), .FL_ADDR(fla), .FL_RDATA(flr), .FL_RCHK(flc),
      .PS_SEL(pss), .PS_ADDR(psa), .PS_WE(pswe), .PS_BE(psbe),
      .PS_WDATA(pswd), .PS_RDATA(psr), .DS_SEL(dss), .DS_ADDR(dsa),
      .DS_WE(dswe), .DS_BE(dsbe), .DS_WDATA(dswd), .DS_RDATA(dsr),
      .FC_PROG(prog), .FC_ERASE(erase), .FC_SECTOR(sect), .FC_WP_PAIR(wp),
      .FC_RP_EN(rp), .FC_PWD_VALID(pv), .FC_PWD(pwd), .FC_BUSY(busy),
      .FC_DONE(done), .FC_REFUSED(refd), .FC_UNLOCKED(unl),
      .FC_SECT_ERASED(serased));

   mmd_mem_model MEM (.fl_addr(fla), .corrupt(corrupt), .fl_rdata(flr),
      .fl_rchk(flc), .ps_addr(psa), .ds_addr(dsa), .ps_rdata(psr),
      .ds_rdata(dsr));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [63:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   function automatic logic [63:0] fl_line(input logic [23:0] a);
      return {8'hc3, a[23:3], 3'b0, 8'h5e, a[23:3], 3'b0};
   endfunction : fl_line

   task automatic fetch(input logic [23:0] a, input logic err,
                        input logic [63:0] exp);
      @(negedge clk);
      freq = 1;
      fadr = a;
      @(negedge clk);
      freq = 0;
      chk("fetch valid", fv, 1'b1);
      chk("fetch err", fe, err);
      chk("fetch data", fd, exp);
   endtask : fetch

   task automatic dacc(input logic [23:0] a, input logic we, by,
                       input logic [15:0] wd, input logic [6:0] sel,
                       input logic ps, err, input logic [15:0] rd);
      @(negedge clk);
      dreq = 1;
      dadr = a;
      dwe = we;
      dbyte = by;
      dwd = wd;
      #1;
      chk("data target", dss, sel);
      chk("program sram sel", pss, ps);
      if (ps) chk("program sram we", pswe, we);
      chk("target addr", ps ? psa : dsa, a);
      if (we) chk("write data", ps ? pswd : dswd, wd);
      if (sel != 0) begin
         chk("target we", dswe, we);
         chk("lanes", dsbe, by ? (a[0] ? 2'b10 : 2'b01) : 2'b11);
      end
      @(negedge clk);
      dreq = 0;
      dwe = 0;
      chk("data valid", dv, 1'b1);
      chk("data err", de, err);
      if (!we) chk("read data", dr, rd);
   endtask : dacc

   task automatic fc_op(input logic e, input logic [2:0] s, input int cyc,
                        input logic refuse);
      int n;
      @(negedge clk);
      prog = !e;
      erase = e;
      sect = s;
      @(negedge clk);
      prog = 0;
      erase = 0;
      chk("refused", refd, refuse);
      chk("busy", busy, !refuse);
      if (!refuse) begin
         n = 0;
         while (!done && n < 100) begin
            @(negedge clk);
            n++;
         end
         chk("done time", n, cyc);
         @(negedge clk);
         chk("sector flag", serased[s], 1'b1);
      end
   endtask : fc_op

   task automatic pword(input logic [15:0] w);
      @(negedge clk);
      pv = 1;
      pwd = w;
      @(negedge clk);
      pv = 0;
   endtask : pword

   ////////////////////////////////////////////////////////////////////////
   task automatic t_fetch;
      fetch(24'hc00008, 0, fl_line(24'hc00008));
      fetch(24'hc0fff8, 0, fl_line(24'hc0fff8));
      fetch(24'hc10000, 1, 64'h0);
      fetch(24'he007f8, 0, {2{8'h96, 24'he007f8}});
      fetch(24'he00800, 1, 64'h0);
      fetch(24'h00f600, 1, 64'h0);
      corrupt = 1;
      fetch(24'hc00010, 0, fl_line(24'hc00010));
      corrupt = 0;
      $display("test fetch finished");
   endtask : t_fetch

   task automatic t_map;
      logic [23:0] a [12] = '{24'h00c000, 24'h00c7fe, 24'h00c800,
         24'h00f600, 24'h00fdfe, 24'h00fe00, 24'h00fffe, 24'h00f000,
         24'h00f1fe, 24'h00f200, 24'h01f600, 24'h00e000};
      logic [6:0] s [12] = '{7'h04, 7'h04, 7'h00, 7'h08, 7'h08, 7'h10,
         7'h10, 7'h20, 7'h20, 7'h00, 7'h00, 7'h00};
      for (int i = 0; i < 12; i++) begin
         dacc(a[i], 0, 0, 16'h0, s[i], 0, s[i] == 0,
              s[i] == 0 ? 16'h0 : a[i][15:0] ^ 16'h0f0f);
      end
      dacc(24'h00fdfe, 0, 0, 16'h0, 7'h08, 0, 0, 16'hf2f1);
      chk("bit addressable", dbit, 1'b1);
      dacc(24'h00fcfe, 0, 0, 16'h0, 7'h08, 0, 0, 16'hf3f1);
      chk("bit addressable", dbit, 1'b0);
      dacc(24'hfff002, 0, 0, 16'h0, 7'h40, 0, 0, 16'h1e9b);
      dacc(24'h00f601, 0, 1, 16'h0, 7'h08, 0, 0, 16'h00f9);
      dacc(24'hc00006, 0, 0, 16'h0, 7'h00, 0, 0, 16'hc3c0);
      dacc(24'hc00007, 0, 1, 16'h0, 7'h00, 0, 0, 16'h00c3);
      $display("test map finished");
   endtask : t_map

   task automatic t_write;
      // only defined locations written, never spare registers
      dacc(24'h00f603, 1, 1, 16'habab, 7'h08, 0, 0, 16'h0);
      dacc(24'h00c002, 1, 0, 16'h1234, 7'h04, 0, 0, 16'h0);
      dacc(24'he00004, 1, 0, 16'h5678, 7'h00, 1, 0, 16'h0);
      dacc(24'hc00000, 1, 0, 16'h1111, 7'h00, 0, 1, 16'h0);
      $display("test write finished");
   endtask : t_write

   task automatic t_flash;
      fc_op(0, 3'd0, 8, 0);
      fc_op(1, 3'd4, 16, 0);
      fc_op(0, 3'd5, 0, 1);
      wp = 2'b01;
      fc_op(0, 3'd1, 0, 1);
      fc_op(0, 3'd2, 8, 0);
      wp = 2'b00;
      $display("test flash control finished");
   endtask : t_flash

   task automatic t_lock;
      rp = 1;
      fetch(24'hc00008, 1, 64'h0);
      pword(PWD_FIRST);
      pword(PWD_SECOND);
      chk("unlocked", unl, 1'b1);
      fetch(24'hc00008, 0, fl_line(24'hc00008));
      repeat (UNLOCK_CYC + 4) @(negedge clk);
      chk("relocked", unl, 1'b0);
      pword(PWD_FIRST);
      pword(16'h1234);
      pword(PWD_SECOND);
      chk("wrong word", unl, 1'b0);
      rp = 0;
      $display("test lock finished");
   endtask : t_lock

   task automatic clash(input logic [23:0] fa, da, input logic we,
                        input logic [15:0] rd);
      @(negedge clk);
      freq = 1;
      fadr = fa;
      dreq = 1;
      dadr = da;
      dwe = we;
      #1;
      chk("stalled write", pswe, 1'b0);
      @(negedge clk);
      freq = 0;
      chk("fetch wins", fv, 1'b1);
      chk("data stalled", dv, 1'b0);
      @(negedge clk);
      dreq = 0;
      dwe = 0;
      chk("data retried", dv, 1'b1);
      if (!we) chk("retried read", dr, rd);
   endtask : clash

   task automatic t_clash;
      clash(24'he00000, 24'he00010, 1, 16'h0);
      clash(24'hc00100, 24'hc00006, 0, 16'hc3c0);
      $display("test clash finished");
   endtask : t_clash

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   initial begin
      #100000;
      n_fail++;
      final_report();
   end

   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      t_fetch();
      t_map();
      t_write();
      t_clash();
      t_flash();
      t_lock();
      final_report();
   end
endmodule : tb_memory_map_address_decoder
